//--- design/nvm_controller.sv
// flash self-program controller: apb registers, latches, read/erase/program sequencer
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - data lock blocks external programmer access
// - rows of 32 words, 32 latches
// - erase/program only outside guarded segments
// - 14-bit hidden latches filled from data pair
// - read uses second cycle, data next cycle
// - data pair holds read word until replaced
// - self reads ignore code lock
// - row erase bit clears at completion
// - erase: two setup cycles, stall 2 ms
// - programming never erases automatically
// - block program aligned, never crosses boundary
// - latches reset to 3FFF after program, not after erase
// - latch only load: deposit, no stall
// - otherwise load last latch, program block
// - whole latch block always programmed
// - program: two setup cycles, stall 2 ms
// - strobes set-only, hardware clears them
// - program strobe needs arm, no abort
// - completion clears strobe, sets done flag
// - reset during write sets abort flag
module nvm_controller #(
  parameter int ARRAY_CYCLES = nvm_pkg::ARRAY_CYCLES,
  parameter int LATCHES      = nvm_pkg::LATCH_COUNT
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // cpu side
  output logic             cpu_stall_o,
  output logic             ext_access_ok_o,
  input  wire logic        ext_request_i,
  // flash array
  output logic             arr_read_o,
  output logic             arr_erase_o,
  output logic             arr_prog_o,
  output logic      [14:0] arr_addr_o,
  output logic      [14:0] arr_latch_idx_o,
  output logic      [13:0] arr_wdata_o,
  input  wire logic [13:0] arr_rdata_i
);

  // ----------------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------------
  logic [7:0]  addr_low;
  logic [6:0]  addr_high;
  logic [7:0]  data_low;
  logic [5:0]  data_high;
  logic        read_strobe;
  logic        prog_strobe;
  logic        modify_arm;
  logic        abort_flag = 1'b0;  // power-on value, kept over reset
  logic        row_erase;
  logic        latch_only_load;
  logic        config_space_sel;
  logic        program_space_sel;
  logic        done_flag;
  logic [3:0]  config_bits;
  logic        in_write;
  logic [13:0] latch [LATCHES];
  nvm_pkg::nvm_state_e state;
  logic [31:0] wait_cnt;
  logic        is_erase;

  logic        acc;
  logic        wr;
  logic        wr_ctrl;
  logic        start_ok;
  logic        unlocked;
  logic        protected_addr;
  logic [14:0] full_addr;
  logic [4:0]  latch_sel;
  logic        read_done;
  logic        op_done;

  assign acc       = psel_i && penable_i;
  assign wr        = acc && pwrite_i;
  assign wr_ctrl   = wr && paddr_i == nvm_pkg::OFS_CONTROL;
  assign pready_o  = 1'b1;
  assign full_addr = {addr_high, addr_low};
  assign latch_sel = addr_low[4:0];

  // ----------------------------------------------------------------------
  // write protection and external access
  // ----------------------------------------------------------------------
  // guard 11 = none, 10 = lower quarter, 01 = lower half, 00 = all
  always_comb
  begin
    case (config_bits[1:0])
      2'b11:   protected_addr = 1'b0;
      2'b10:   protected_addr = full_addr[14:13] == 2'b00;
      2'b01:   protected_addr = !full_addr[14];
      default: protected_addr = 1'b1;
    endcase
  end

  // external programmer allowed only with neither lock programmed low
  assign ext_access_ok_o = ext_request_i && config_bits[nvm_pkg::BIT_DATA_LOCK]
                           && config_bits[nvm_pkg::BIT_CODE_LOCK];

  nvm_unlock u_unlock
  (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .wr_any_i   (wr && !wr_ctrl),
    .wr_key_i   (wr && paddr_i == nvm_pkg::OFS_KEY_PORT),
    .wdata_i    (pwdata_i[7:0]),
    .consume_i  (wr_ctrl),
    .unlocked_o (unlocked)
  );

  // strobe accepted only with arm set, unlock armed, program space and not busy
  assign start_ok = wr_ctrl && pwdata_i[nvm_pkg::BIT_PROG_STROBE] && modify_arm
                    && unlocked && program_space_sel && !config_space_sel
                    && state == nvm_pkg::ST_IDLE;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  assign read_done = state == nvm_pkg::ST_READ;
  assign op_done   = state == nvm_pkg::ST_FINISH;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state    <= nvm_pkg::ST_IDLE;
      wait_cnt <= 32'h0;
      is_erase <= 1'b0;
    end
    else
    begin
      case (state)
        nvm_pkg::ST_IDLE:
        begin
          if (wr_ctrl && pwdata_i[nvm_pkg::BIT_READ_STROBE] && program_space_sel
              && !config_space_sel)
            state <= nvm_pkg::ST_READ;
          else if (start_ok && !protected_addr
                   && (pwdata_i[nvm_pkg::BIT_ROW_ERASE]
                       || !pwdata_i[nvm_pkg::BIT_LATCH_ONLY]))
          begin
            state    <= nvm_pkg::ST_SETUP;
            is_erase <= pwdata_i[nvm_pkg::BIT_ROW_ERASE];
            wait_cnt <= 32'(nvm_pkg::SETUP_CYCLES - 1);
          end
        end
        nvm_pkg::ST_READ:
          state <= nvm_pkg::ST_IDLE;
        nvm_pkg::ST_SETUP:
        begin
          if (wait_cnt == 32'h0)
          begin
            state    <= nvm_pkg::ST_BUSY;
            wait_cnt <= 32'(ARRAY_CYCLES - 1);
          end
          else
            wait_cnt <= wait_cnt - 32'h1;
        end
        nvm_pkg::ST_BUSY:
        begin
          if (wait_cnt == 32'h0)
            state <= nvm_pkg::ST_FINISH;
          else
            wait_cnt <= wait_cnt - 32'h1;
        end
        nvm_pkg::ST_FINISH:
          state <= nvm_pkg::ST_IDLE;
        default:
          state <= nvm_pkg::ST_IDLE;
      endcase
    end
  end

  // stall the cpu only during the array operation, never for a latch load
  assign cpu_stall_o = state == nvm_pkg::ST_BUSY;
  assign arr_read_o  = state == nvm_pkg::ST_READ;
  assign arr_erase_o = state == nvm_pkg::ST_BUSY && is_erase;
  assign arr_prog_o  = state == nvm_pkg::ST_BUSY && !is_erase;
  // block aligned to the latch boundary, low five bits forced to zero
  assign arr_addr_o  = {full_addr[14:5], 5'h00};

  // ----------------------------------------------------------------------
  // write latches, streamed to the array during programming
  // ----------------------------------------------------------------------
  logic [14:0] prog_idx;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      prog_idx <= 15'h0;
    else if (state == nvm_pkg::ST_BUSY && !is_erase)
      prog_idx <= (prog_idx == 15'(LATCHES - 1)) ? 15'h0 : prog_idx + 15'h1;
    else
      prog_idx <= 15'h0;
  end

  assign arr_latch_idx_o = prog_idx;
  assign arr_wdata_o     = latch[prog_idx[4:0]];

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || (op_done && !is_erase))
    begin
      for (int i = 0; i < LATCHES; i++)
        latch[i] <= nvm_pkg::LATCH_RESET;
    end
    else if (start_ok && !protected_addr && !pwdata_i[nvm_pkg::BIT_ROW_ERASE])
      latch[latch_sel] <= {data_high, data_low};
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      addr_low  <= 8'h00;
      addr_high <= 7'h00;
      data_low  <= 8'h00;
      data_high <= 6'h00;
    end
    else
    begin
      if (wr && paddr_i == nvm_pkg::OFS_ADDR_LOW)
        addr_low <= pwdata_i[7:0];
      if (wr && paddr_i == nvm_pkg::OFS_ADDR_HIGH)
        addr_high <= pwdata_i[6:0];
      if (read_done)
      begin
        data_low  <= arr_rdata_i[7:0];
        data_high <= arr_rdata_i[13:8];
      end
      else
      begin
        if (wr && paddr_i == nvm_pkg::OFS_DATA_LOW)
          data_low <= pwdata_i[7:0];
        if (wr && paddr_i == nvm_pkg::OFS_DATA_HIGH)
          data_high <= pwdata_i[5:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      modify_arm        <= 1'b0;
      latch_only_load   <= 1'b0;
      config_space_sel  <= 1'b0;
      program_space_sel <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // clearing the arm later never aborts a running operation
      modify_arm        <= pwdata_i[nvm_pkg::BIT_MODIFY_ARM];
      latch_only_load   <= pwdata_i[nvm_pkg::BIT_LATCH_ONLY];
      config_space_sel  <= pwdata_i[nvm_pkg::BIT_CONFIG_SPACE];
      program_space_sel <= pwdata_i[nvm_pkg::BIT_PROGRAM_SPACE];
    end
  end

  // strobes: set-only by software, cleared by hardware
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      read_strobe <= 1'b0;
      prog_strobe <= 1'b0;
      row_erase   <= 1'b0;
    end
    else
    begin
      if (read_done)
        read_strobe <= 1'b0;
      else if (wr_ctrl && pwdata_i[nvm_pkg::BIT_READ_STROBE] && state == nvm_pkg::ST_IDLE
               && program_space_sel && !config_space_sel)
        read_strobe <= 1'b1;
      if (op_done)
        prog_strobe <= 1'b0;
      else if (start_ok && !protected_addr && !pwdata_i[nvm_pkg::BIT_LATCH_ONLY])
        prog_strobe <= 1'b1;
      if (op_done && is_erase)
        row_erase <= 1'b0;
      else if (wr_ctrl && state == nvm_pkg::ST_IDLE)
        row_erase <= pwdata_i[nvm_pkg::BIT_ROW_ERASE];
    end
  end

  // done flag: set wins over write-one-to-clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      done_flag <= 1'b0;
    else if (op_done)
      done_flag <= 1'b1;
    else if (wr && paddr_i == nvm_pkg::OFS_FLAGS && pwdata_i[nvm_pkg::BIT_DONE_FLAG])
      done_flag <= 1'b0;
  end

  // abort_flag is kept over reset; in_write is cleared by reset but first sets abort_flag if high, to detect an interrupted write
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      in_write <= 1'b0;
      if (in_write)
        abort_flag <= 1'b1;
    end
    else
    begin
      in_write <= state == nvm_pkg::ST_SETUP || state == nvm_pkg::ST_BUSY;
      if (wr_ctrl && !pwdata_i[nvm_pkg::BIT_ABORT_FLAG])
        abort_flag <= 1'b0;
    end
  end

  // configuration word: guard and lock bits, loaded by software
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      config_bits <= nvm_pkg::CONFIG_RESET;
    else if (wr && paddr_i == nvm_pkg::OFS_CONFIG && state == nvm_pkg::ST_IDLE)
      config_bits <= pwdata_i[3:0];
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    prdata_o  = 32'h0;
    pslverr_o = 1'b0;
    case (paddr_i)
      nvm_pkg::OFS_ADDR_LOW:  prdata_o = {24'h0, addr_low};
      nvm_pkg::OFS_ADDR_HIGH: prdata_o = {25'h0, addr_high};
      nvm_pkg::OFS_DATA_LOW:  prdata_o = {24'h0, data_low};
      nvm_pkg::OFS_DATA_HIGH: prdata_o = {26'h0, data_high};
      nvm_pkg::OFS_CONTROL:   prdata_o = {24'h0, program_space_sel, config_space_sel,
                                          latch_only_load, row_erase, abort_flag,
                                          modify_arm, prog_strobe, read_strobe};
      nvm_pkg::OFS_KEY_PORT:  prdata_o = 32'h0;
      nvm_pkg::OFS_FLAGS:     prdata_o = {31'h0, done_flag};
      nvm_pkg::OFS_CONFIG:    prdata_o = {28'h0, config_bits};
      default:                pslverr_o = acc;
    endcase
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_strobe_accepted;
    start_ok && !protected_addr && !pwdata_i[nvm_pkg::BIT_LATCH_ONLY];
  endsequence

  a_setup_two_cycles : assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_strobe_accepted |=> !cpu_stall_o [*2] ##1 cpu_stall_o)
    else $error("stall not after two setup cycles");
  a_latch_no_stall : assert property (@(posedge clk_i) disable iff (!rstn_i)
    start_ok && pwdata_i[nvm_pkg::BIT_LATCH_ONLY] && !pwdata_i[nvm_pkg::BIT_ROW_ERASE]
    |=> !cpu_stall_o [*3])
    else $error("latch load stalled cpu");
  a_read_next_cycle : assert property (@(posedge clk_i) disable iff (!rstn_i)
    arr_read_o |=> data_low == $past(arr_rdata_i[7:0]) && !read_strobe)
    else $error("read data not loaded");
  a_done_sets_flag : assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_done |=> done_flag && !prog_strobe)
    else $error("completion flag missing");
  a_protect_blocks : assert property (@(posedge clk_i) disable iff (!rstn_i)
    state == nvm_pkg::ST_IDLE && protected_addr |=> state != nvm_pkg::ST_SETUP)
    else $error("write into guarded segment");
  a_arm_required : assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(prog_strobe) |-> $past(modify_arm))
    else $error("strobe without arm");
  a_latch_reset : assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_done && !is_erase |=> latch[0] == nvm_pkg::LATCH_RESET)
    else $error("latches not reset");
  a_erase_bit_clear : assert property (@(posedge clk_i) disable iff (!rstn_i)
    op_done && is_erase |=> !row_erase)
    else $error("row erase bit not cleared");

endmodule : nvm_controller

//--- design/nvm_pkg.sv
// package: register offsets, field positions, reset values and timing for the flash controller
package nvm_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets (apb, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR_LOW   = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH  = 8'h04;
  localparam logic [7:0] OFS_DATA_LOW   = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH  = 8'h0C;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_KEY_PORT   = 8'h14;
  localparam logic [7:0] OFS_FLAGS      = 8'h18;
  localparam logic [7:0] OFS_CONFIG     = 8'h1C;

  // ----------------------------------------------------------------------
  // nvm_control field positions
  // ----------------------------------------------------------------------
  localparam int BIT_READ_STROBE  = 0;
  localparam int BIT_PROG_STROBE  = 1;
  localparam int BIT_MODIFY_ARM   = 2;
  localparam int BIT_ABORT_FLAG   = 3;
  localparam int BIT_ROW_ERASE    = 4;
  localparam int BIT_LATCH_ONLY   = 5;
  localparam int BIT_CONFIG_SPACE = 6;
  localparam int BIT_PROGRAM_SPACE = 7;

  // flags register: done flag in bit 0, write 1 to clear
  localparam int BIT_DONE_FLAG    = 0;

  // config register: segment_guard [1:0], code_lock [2], data_array_lock [3]
  localparam int BIT_CODE_LOCK    = 2;
  localparam int BIT_DATA_LOCK    = 3;

  // ----------------------------------------------------------------------
  // key values and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;
  localparam logic [13:0] LATCH_RESET  = 14'h3FFF;
  localparam logic [3:0]  CONFIG_RESET = 4'hF;

  // ----------------------------------------------------------------------
  // organisation and timing
  // ----------------------------------------------------------------------
  localparam int ROW_WORDS        = 32;
  localparam int LATCH_COUNT      = 32;
  localparam int SETUP_CYCLES     = 2;
  localparam int CLK_MHZ          = 200;
  localparam int ARRAY_TIME_US    = 2000;
  localparam int ARRAY_CYCLES     = ARRAY_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_SETUP   = 3'b010,
    ST_BUSY    = 3'b011,
    ST_FINISH  = 3'b100
  } nvm_state_e;

endpackage : nvm_pkg

//--- design/nvm_unlock.sv
// unlock detector: 55h then aah on the key port, then the program strobe
`timescale 1ns/1ps

module nvm_unlock
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // register write events
  input  wire logic       wr_any_i,
  input  wire logic       wr_key_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       consume_i,
  // armed state
  output logic            unlocked_o
);

  logic [1:0] stage;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      stage <= 2'h0;
    else if (consume_i)
      stage <= 2'h0;
    else if (wr_any_i)
    begin
      // any other write between the keys discards progress
      if (wr_key_i && wdata_i == nvm_pkg::KEY_FIRST && stage == 2'h0)
        stage <= 2'h1;
      else if (wr_key_i && wdata_i == nvm_pkg::KEY_SECOND && stage == 2'h1)
        stage <= 2'h2;
      else
        stage <= 2'h0;
    end
  end

  assign unlocked_o = (stage == 2'h2);

  a_unlock_needs_keys : assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(unlocked_o) |-> $past(wr_key_i) && $past(wdata_i) == nvm_pkg::KEY_SECOND)
    else $error("unlock armed without second key");

endmodule : nvm_unlock

//--- verification/flash_array_model.sv
// flash array stand-in: fixed word on reads, churning data otherwise
`timescale 1ns/1ps

module flash_array_model #(
  parameter logic [13:0] READ_WORD = 14'h1A5C
)
(
  // clock
  input  wire logic        clk_i,
  // read strobe from the controller
  input  wire logic        arr_read_i,
  // read data
  output logic      [13:0] arr_rdata_o
);
  logic phase = 1'b0;

  always @(posedge clk_i) phase <= ~phase;

  // outside a read the bus never holds the word, so a late sample shows up
  assign arr_rdata_o = arr_read_i ? READ_WORD : {7{phase, ~phase}};
endmodule : flash_array_model

//--- verification/tb_flash_self_program_controller.sv
// testbench: apb register sequences against the flash controller
`timescale 1ns/1ps

module tb_flash_self_program_controller;
  localparam int ARR = 40;
  localparam logic [7:0] ALO = nvm_pkg::OFS_ADDR_LOW;
  localparam logic [7:0] AHI = nvm_pkg::OFS_ADDR_HIGH;
  localparam logic [7:0] DLO = nvm_pkg::OFS_DATA_LOW;
  localparam logic [7:0] DHI = nvm_pkg::OFS_DATA_HIGH;
  localparam logic [7:0] CTL = nvm_pkg::OFS_CONTROL;
  localparam logic [7:0] KEY = nvm_pkg::OFS_KEY_PORT;
  localparam logic [7:0] FLG = nvm_pkg::OFS_FLAGS;
  localparam logic [7:0] CFG = nvm_pkg::OFS_CONFIG;
  localparam logic [31:0] LRST = {18'h0, nvm_pkg::LATCH_RESET};

  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rv;
  logic        pready_o, pslverr_o, cpu_stall_o, ext_access_ok_o, ev;
  logic        ext_request_i = 1'b0;
  logic        arr_read_o, arr_erase_o, arr_prog_o;
  logic        erase_seen = 1'b0;
  logic [14:0] arr_addr_o, arr_latch_idx_o;
  logic [14:0] blk_seen = 15'h0;
  logic [13:0] arr_wdata_o, arr_rdata_i;
  logic [13:0] wseen [32];
  int          err_total = 0;
  int          total_checks = 0;
  int          stall_cnt = 0;
  int          s0;

  always #2.5 clk_i = ~clk_i;

  nvm_controller #(.ARRAY_CYCLES(ARR)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_stall_o(cpu_stall_o),
    .ext_access_ok_o(ext_access_ok_o), .ext_request_i(ext_request_i),
    .arr_read_o(arr_read_o), .arr_erase_o(arr_erase_o), .arr_prog_o(arr_prog_o),
    .arr_addr_o(arr_addr_o), .arr_latch_idx_o(arr_latch_idx_o),
    .arr_wdata_o(arr_wdata_o), .arr_rdata_i(arr_rdata_i));

  flash_array_model array_u (.clk_i(clk_i), .arr_read_i(arr_read_o), .arr_rdata_o(arr_rdata_i));

  // ----------------------------------------------------------------------
  // array-side monitor
  // ----------------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (cpu_stall_o === 1'b1) stall_cnt <= stall_cnt + 1;
    if (arr_erase_o === 1'b1) erase_seen <= 1'b1;
    if (arr_prog_o === 1'b1)
    begin
      wseen[arr_latch_idx_o[4:0]] <= arr_wdata_o;
      blk_seen <= arr_addr_o;
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) err_total++;
    rv = prdata_o;
    ev = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, string s);
    apb(1'b0, a, 32'h0);
    chk(s, rv & m, e);
  endtask : rd

  task automatic go(input logic [31:0] ctl);
    apb(1'b1, KEY, {24'h0, nvm_pkg::KEY_FIRST});
    apb(1'b1, KEY, {24'h0, nvm_pkg::KEY_SECOND});
    apb(1'b1, CTL, ctl);
  endtask : go

  task automatic wait_idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, CTL, 32'h0);
      n++;
    end
    while ((rv[4] | rv[1]) !== 1'b0 && n < 40);
    chk("idle wait", 32'(rv[4] | rv[1]), 32'h0);
  endtask : wait_idle

  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #100000;
    err_total++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(CFG, 32'hF, {28'h0, nvm_pkg::CONFIG_RESET}, "config reset");
    rd(CTL, 32'hFF, 32'h0, "control reset");
    ext_request_i <= 1'b1;
    apb(1'b1, CFG, 32'h7);
    chk("ext blocked", 32'(ext_access_ok_o), 32'h0);
    apb(1'b1, CFG, 32'hB);
    apb(1'b1, ALO, 32'h43);
    apb(1'b1, AHI, 32'h0A);
    apb(1'b1, CTL, 32'h80);
    apb(1'b1, CTL, 32'h81);
    rd(DLO, 32'hFF, 32'h5C, "read low");
    rd(DHI, 32'h3F, 32'h1A, "read high");
    rd(CTL, 32'h1, 32'h0, "read strobe");
    apb(1'b1, DLO, 32'h77);
    rd(DLO, 32'hFF, 32'h77, "data low kept");
    rd(DHI, 32'h3F, 32'h1A, "data high kept");
    apb(1'b1, CFG, 32'hF);
    chk("ext allowed", 32'(ext_access_ok_o), 32'h1);
    ext_request_i <= 1'b0;
    s0 = stall_cnt;
    go(32'h82);
    rd(CTL, 32'h2, 32'h0, "unarmed strobe");
    apb(1'b1, CTL, 32'h84);
    apb(1'b1, KEY, 32'h55);
    apb(1'b1, ALO, 32'h43);
    apb(1'b1, KEY, 32'hAA);
    apb(1'b1, CTL, 32'h86);
    rd(CTL, 32'h2, 32'h0, "broken unlock");
    for (int g = 0; g < 3; g++)
    begin
      apb(1'b1, CFG, 32'hC | g);
      go(32'h96);
      rd(CTL, 32'h2, 32'h0, "guarded erase");
    end
    apb(1'b1, CFG, 32'hF);
    chk("refused stall", 32'(stall_cnt - s0), 32'h0);
    chk("refused erase", 32'(erase_seen), 32'h0);
    go(32'h96);
    rd(CTL, 32'h10, 32'h10, "erase select held");
    wait_idle;
    chk("erase select cleared", 32'(rv[4]), 32'h0);
    chk("erase stall", 32'(stall_cnt - s0), ARR);
    chk("erase seen", 32'(erase_seen), 32'h1);
    rd(FLG, 32'h1, 32'h1, "done set");
    apb(1'b1, FLG, 32'h1);
    rd(FLG, 32'h1, 32'h0, "done cleared");
    s0 = stall_cnt;
    apb(1'b1, DLO, 32'h23);
    apb(1'b1, DHI, 32'h01);
    go(32'hA6);
    rd(FLG, 32'h1, 32'h0, "latch load no done");
    chk("latch load stall", 32'(stall_cnt - s0), 32'h0);
    apb(1'b1, ALO, 32'h5F);
    apb(1'b1, DLO, 32'h56);
    apb(1'b1, DHI, 32'h04);
    go(32'h86);
    wait_idle;
    chk("strobe cleared", 32'(rv[1]), 32'h0);
    chk("program stall", 32'(stall_cnt - s0), ARR);
    chk("loaded latch", {18'h0, wseen[3]}, 32'h0123);
    chk("last latch", {18'h0, wseen[31]}, 32'h0456);
    chk("unloaded latch", {18'h0, wseen[0]}, LRST);
    chk("block address", {17'h0, blk_seen}, 32'h0A40);
    go(32'h86);
    wait_idle;
    chk("latches reset", {18'h0, wseen[3]}, LRST);
    go(32'h86);
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(CTL, 32'h8, 32'h8, "abort flag");
    apb(1'b1, CTL, 32'h0);
    rd(CTL, 32'h8, 32'h0, "abort cleared");
    rd(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk("unmapped error", 32'(ev), 32'h1);
    tally_and_finish;
  end
endmodule : tb_flash_self_program_controller
